// file: rtl/twd_pkg.sv
// twd_pkg: constants, register map and carrier types of the timer and
// watchdog block.
// assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package twd_pkg;

    // ************************************************************
    // bus and data widths
    // ************************************************************
    localparam int TWD_DW = 32;
    localparam int TWD_AW = 8;
    localparam int TWD_NTMR = 2;

    typedef logic [TWD_DW-1:0] twd_word_t;
    typedef logic [TWD_AW-1:0] twd_addr_t;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam twd_addr_t OFS_CTRL = 8'h00;
    localparam twd_addr_t OFS_T0_PERIOD = 8'h04;
    localparam twd_addr_t OFS_T0_PULSE = 8'h08;
    localparam twd_addr_t OFS_T1_PERIOD = 8'h0C;
    localparam twd_addr_t OFS_T1_PULSE = 8'h10;
    localparam twd_addr_t OFS_T0_COUNT = 8'h14;
    localparam twd_addr_t OFS_T1_COUNT = 8'h18;
    localparam twd_addr_t OFS_INT_STAT = 8'h1C;
    localparam twd_addr_t OFS_INT_MASK = 8'h20;
    localparam twd_addr_t OFS_STATUS = 8'h24;
    localparam twd_addr_t OFS_WD_KICK = 8'h28;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_WD_BIT = 4;
    localparam int CTRL_PIN_LSB = 5;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [TWD_NTMR-1:0] INT_RST = 2'h0;
    localparam twd_word_t WORD_RST = 32'h0000_0000;
    localparam int STATUS_WRST_BIT = 2;
    localparam int STATUS_PULSE_LSB = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int WRST_MIN_MS = 200;
    // least hold time, exact at this rate so no rounding is lost
    localparam int WRST_CYCLES = (CLK_HZ / 1000) * WRST_MIN_MS;
    localparam int WRST_CW = 23;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        twd_word_t period;
        twd_word_t pulse;
    } twd_tmr_cfg_s;

endpackage

// file: rtl/twd_timer_wdog.sv
// twd_timer_wdog: two 32-bit timers, one able to act as watchdog, with
// reset-out stretching and an AXI4-Lite register slave.
// assumes all inputs synchronous to sys_clk; pin tristate resolved outside.
`timescale 1ns/1ps
module twd_timer_wdog
    import twd_pkg::*;
#(
    parameter int unsigned WRST_HOLD_CYCLES = WRST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic chip_reset_low_in,
    input wire logic [TWD_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [TWD_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TWD_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [TWD_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic core_reset_req,
    output logic watchdog_reset_out,
    output logic watchdog_reset_out_oe,
    output logic [TWD_NTMR-1:0] timer_pin_out,
    output logic [TWD_NTMR-1:0] timer_pin_oe
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic addr_mapped(input twd_addr_t a);
        logic hit;
        hit = (a[1:0] == 2'h0) && (a <= OFS_WD_KICK);
        return hit;
    endfunction

    function automatic twd_word_t merge(input twd_word_t old,
                                        input twd_word_t nw,
                                        input logic [3:0] strb);
        twd_word_t res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic aw_held_r, w_held_r;
    twd_addr_t aw_addr_r;
    twd_word_t w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    twd_word_t rdata_r;

    logic [CTRL_W-1:0] ctrl_r;
    twd_tmr_cfg_s cfg_r [TWD_NTMR];
    twd_word_t cnt_r [TWD_NTMR];
    twd_word_t pulse_cnt_r [TWD_NTMR];
    twd_word_t pulse_cnt_nxt [TWD_NTMR];
    logic [TWD_NTMR-1:0] stat_r, stat_nxt, mask_r;
    logic [TWD_NTMR-1:0] timeout;
    logic [TWD_NTMR-1:0] pin_out_r, pin_oe_r;
    logic irq_r, core_rst_r, wd_fire_r;
    logic [WRST_CW-1:0] wrst_cnt_r, wrst_cnt_nxt;
    logic wrst_out_r, wrst_oe_r;

    logic do_write, wd_fire, kick, soft_clr, in_reset;
    logic [TWD_NTMR-1:0] tmr_en, pin_sel;

    assign tmr_en = ctrl_r[CTRL_EN_LSB +: TWD_NTMR];
    assign pin_sel = ctrl_r[CTRL_PIN_LSB +: TWD_NTMR];
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign kick = do_write && (aw_addr_r == OFS_WD_KICK);
    assign in_reset = !chip_reset_low_in;
    // watchdog expiry clears block state the cycle after it fires
    assign soft_clr = in_reset || wd_fire_r;

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // aw and w are taken in either order; the answer follows both
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (in_reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
        end else begin
            if (!aw_held_r && !bvalid_r && !awready_r && !w_held_r) begin
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
            if (s_axi_awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    function automatic twd_word_t rd_word(input twd_addr_t a);
        twd_word_t v;
        v = WORD_RST;
        unique case (a)
            OFS_CTRL: v[CTRL_W-1:0] = ctrl_r;
            OFS_T0_PERIOD: v = cfg_r[0].period;
            OFS_T0_PULSE: v = cfg_r[0].pulse;
            OFS_T1_PERIOD: v = cfg_r[1].period;
            OFS_T1_PULSE: v = cfg_r[1].pulse;
            OFS_T0_COUNT: v = cnt_r[0];
            OFS_T1_COUNT: v = cnt_r[1];
            OFS_INT_STAT: v[TWD_NTMR-1:0] = stat_r;
            OFS_INT_MASK: v[TWD_NTMR-1:0] = mask_r;
            OFS_STATUS: begin
                v[STATUS_PULSE_LSB +: TWD_NTMR] = pin_out_r;
                v[STATUS_WRST_BIT] = wrst_out_r;
            end
            default: v = WORD_RST;
        endcase
        return v;
    endfunction

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (in_reset) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
        end else begin
            if (!rvalid_r && !arready_r) begin
                arready_r <= 1'b1;
            end
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_word(s_axi_araddr);
                rresp_r <= addr_mapped(s_axi_araddr) ? RESP_OKAY
                                                     : RESP_SLVERR;
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= CTRL_RST;
            mask_r <= INT_RST;
            for (int i = 0; i < TWD_NTMR; i++) begin
                cfg_r[i] <= '0;
            end
        end else if (soft_clr) begin
            ctrl_r <= CTRL_RST;
            mask_r <= INT_RST;
            for (int i = 0; i < TWD_NTMR; i++) begin
                cfg_r[i] <= '0;
            end
        end else if (do_write) begin
            unique case (aw_addr_r)
                OFS_CTRL: ctrl_r <= CTRL_W'(merge(32'(ctrl_r), w_data_r,
                                                  w_strb_r));
                OFS_T0_PERIOD: cfg_r[0].period <= merge(cfg_r[0].period,
                                                        w_data_r, w_strb_r);
                OFS_T0_PULSE: cfg_r[0].pulse <= merge(cfg_r[0].pulse,
                                                      w_data_r, w_strb_r);
                OFS_T1_PERIOD: cfg_r[1].period <= merge(cfg_r[1].period,
                                                        w_data_r, w_strb_r);
                OFS_T1_PULSE: cfg_r[1].pulse <= merge(cfg_r[1].pulse,
                                                      w_data_r, w_strb_r);
                OFS_INT_MASK: begin
                    if (w_strb_r[0]) begin
                        mask_r <= w_data_r[TWD_NTMR-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // timers
    // ************************************************************
    // a disabled timer holds its period, so enabling starts a full count
    always_comb begin
        for (int i = 0; i < TWD_NTMR; i++) begin
            timeout[i] = tmr_en[i] && (cnt_r[i] == 32'h0000_0000);
            if (soft_clr) begin
                pulse_cnt_nxt[i] = 32'h0000_0000;
            end else if (timeout[i]) begin
                pulse_cnt_nxt[i] = cfg_r[i].pulse;
            end else if (pulse_cnt_r[i] != 32'h0000_0000) begin
                pulse_cnt_nxt[i] = pulse_cnt_r[i] - 32'h0000_0001;
            end else begin
                pulse_cnt_nxt[i] = 32'h0000_0000;
            end
        end
    end

    // only timer 1 can be the watchdog
    assign wd_fire = ctrl_r[CTRL_WD_BIT] && timeout[1];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < TWD_NTMR; i++) begin
                cnt_r[i] <= 32'h0000_0000;
                pulse_cnt_r[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < TWD_NTMR; i++) begin
                pulse_cnt_r[i] <= pulse_cnt_nxt[i];
                if (soft_clr) begin
                    cnt_r[i] <= 32'h0000_0000;
                end else if (!tmr_en[i] || timeout[i]) begin
                    cnt_r[i] <= cfg_r[i].period;
                end else if (i == 1 && kick) begin
                    cnt_r[i] <= cfg_r[i].period;
                end else begin
                    cnt_r[i] <= cnt_r[i] - 32'h0000_0001;
                end
            end
        end
    end

    // ************************************************************
    // timer pins
    // ************************************************************
    // unselected pins stay undriven so the general pin logic owns them
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_out_r <= 2'h0;
            pin_oe_r <= 2'h0;
        end else begin
            for (int i = 0; i < TWD_NTMR; i++) begin
                pin_out_r[i] <= pulse_cnt_nxt[i] != 32'h0000_0000;
                pin_oe_r[i] <= pin_sel[i] && !soft_clr;
            end
        end
    end

    // ************************************************************
    // interrupt status and output
    // ************************************************************
    // a timeout in the cycle of a write-one clear keeps the bit set
    always_comb begin
        stat_nxt = stat_r;
        if (do_write && aw_addr_r == OFS_INT_STAT && w_strb_r[0]) begin
            stat_nxt = stat_nxt & ~w_data_r[TWD_NTMR-1:0];
        end
        stat_nxt = stat_nxt | timeout;
        if (soft_clr) begin
            stat_nxt = INT_RST;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stat_r <= INT_RST;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & mask_r) && !soft_clr;
        end
    end

    // ************************************************************
    // watchdog reset and reset-out stretch
    // ************************************************************
    // the stretch counter survives the soft clear it causes, otherwise
    // the pulse would end as soon as the block reset itself
    always_comb begin
        if (wd_fire) begin
            wrst_cnt_nxt = WRST_CW'(WRST_HOLD_CYCLES);
        end else if (wrst_cnt_r != '0) begin
            wrst_cnt_nxt = wrst_cnt_r - WRST_CW'(1);
        end else begin
            wrst_cnt_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wd_fire_r <= 1'b0;
            core_rst_r <= 1'b0;
            wrst_cnt_r <= '0;
            wrst_out_r <= 1'b0;
            wrst_oe_r <= 1'b0;
        end else begin
            wd_fire_r <= wd_fire && !in_reset;
            core_rst_r <= in_reset || wd_fire;
            wrst_cnt_r <= wrst_cnt_nxt;
            wrst_out_r <= wrst_cnt_nxt != '0;
            wrst_oe_r <= !in_reset;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = irq_r;
    assign core_reset_req = core_rst_r;
    assign watchdog_reset_out = wrst_out_r;
    assign watchdog_reset_out_oe = wrst_oe_r;
    assign timer_pin_out = pin_out_r;
    assign timer_pin_oe = pin_oe_r;

endmodule

// file: sim/twd_timer_wdog_checker.sv
// twd_timer_wdog_checker: port assertions for the timer and watchdog block.
// assumes a bind onto twd_timer_wdog; one clock, async active-high reset.
`timescale 1ns/1ps
module twd_timer_wdog_checker
    import twd_pkg::*;
#(
    parameter int unsigned WRST_HOLD_CYCLES = WRST_CYCLES
) (
    input logic sys_clk,
    input logic reset,
    input logic chip_reset_low_in,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [TWD_DW-1:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic irq,
    input logic core_reset_req,
    input logic watchdog_reset_out,
    input logic watchdog_reset_out_oe,
    input logic [TWD_NTMR-1:0] timer_pin_out,
    input logic [TWD_NTMR-1:0] timer_pin_oe
);
    // ********
    // helpers
    // ********
    // length of the current reset-out assertion, in clocks
    int unsigned hi_cnt;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= watchdog_reset_out ? hi_cnt + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence chip_held;
        !chip_reset_low_in [*3];
    endsequence
    // ********
    // assertions
    // ********
    core_req_a: assert property (!chip_reset_low_in |=> core_reset_req)
        else $error("core reset request missing in chip reset");
    pin_float_a: assert property (!chip_reset_low_in |=>
        !watchdog_reset_out_oe && timer_pin_oe == 2'h0)
        else $error("pin driver enabled during chip reset");
    chip_quiet_a: assert property (chip_held |->
        !irq && timer_pin_out == 2'h0)
        else $error("timer activity during chip reset");
    wd_fire_a: assert property ($rose(watchdog_reset_out) |->
        core_reset_req)
        else $error("reset-out without internal reset");
    wrst_hold_a: assert property ($fell(watchdog_reset_out) |->
        hi_cnt >= WRST_HOLD_CYCLES)
        else $error("reset-out released too early");
    wr_resp_a: assert property (wr_taken |=>
        !s_axi_awready ##1 s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (rd_taken |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready &&
        chip_reset_low_in |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule

// file: sim/twd_reset_target.sv
// twd_reset_target: devices on the board reset by the reset-out line.
// assumes a pull-down holds the line inactive while the pin floats.
`timescale 1ns/1ps
module twd_reset_target (
    input logic sys_clk,
    input logic reset,
    input logic watchdog_reset_out,
    input logic watchdog_reset_out_oe,
    output int n_resets,
    output int last_len
);
    logic line;
    int run;
    // floated pin reads as the pull-down level, not the last value
    assign line = watchdog_reset_out_oe ? watchdog_reset_out : 1'b0;
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            n_resets <= 0;
            last_len <= 0;
            run <= 0;
        end else if (line) begin
            n_resets <= (run == 0) ? n_resets + 1 : n_resets;
            run <= run + 1;
        end else if (run != 0) begin
            last_len <= run;
            run <= 0;
        end
    end
endmodule

// file: sim/testbench.sv
// testbench: register-level tests of the timer and watchdog block.
// assumes twd_pkg, the design and twd_reset_target are compiled first.
`timescale 1ns/1ps
module testbench
    import twd_pkg::*;
();
    localparam int unsigned HOLD = 20;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic chip_reset_low_in = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    twd_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    twd_word_t s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic irq, core_reset_req, watchdog_reset_out, watchdog_reset_out_oe;
    logic [1:0] timer_pin_out, timer_pin_oe;
    int n_errors = 0, n_tests = 0, cyc = 0, n_resets, last_len, hi, per;

    twd_timer_wdog #(.WRST_HOLD_CYCLES(HOLD)) twd_timer_wdog_i (.*);
    twd_reset_target twd_reset_target_i (.*);

    always #12.5 sys_clk = ~sys_clk;
    // ********
    // tasks
    // ********
    task automatic print_verdict();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    // ready sampled at the falling edge equals what the next rise takes
    task automatic wr(input twd_addr_t a, input twd_word_t d,
                      output logic [1:0] rs);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge sys_clk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            @(posedge sys_clk);
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        do @(negedge sys_clk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdx(input twd_addr_t a, input twd_word_t e,
                       input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge sys_clk); while (!s_axi_arready);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        // late rready makes the slave hold rvalid and rdata one cycle
        @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do @(negedge sys_clk); while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic wro(input twd_addr_t a, input twd_word_t d);
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    // pulse width and spacing between rising edges of one timer pin
    task automatic meas(input int i);
        do @(negedge sys_clk); while (!timer_pin_out[i]);
        hi = 0;
        per = 0;
        while (timer_pin_out[i]) begin
            hi++;
            per++;
            @(negedge sys_clk);
        end
        while (!timer_pin_out[i]) begin
            per++;
            @(negedge sys_clk);
        end
    endtask
    // ********
    // tests
    // ********
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int a = 0; a <= 8'h28; a += 4) begin
            rdx(a[7:0], 32'h0, RESP_OKAY);
        end
        rdx(8'h2C, 32'h0, RESP_SLVERR);
        wr(8'h30, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wro(OFS_T0_COUNT, 32'h5);
        rdx(OFS_T0_COUNT, 32'h0, RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            wro(i ? OFS_T1_PERIOD : OFS_T0_PERIOD, 32'h4 + i);
            wro(i ? OFS_T1_PULSE : OFS_T0_PULSE, 32'h2 + i);
            rdx(i ? OFS_T1_PULSE : OFS_T0_PULSE, 32'h2 + i, RESP_OKAY);
            wro(OFS_INT_MASK, 32'h0);
            wro(OFS_CTRL, 32'h21 << i);
            meas(i);
            chk(hi, 2 + i);
            chk(per, 5 + i);
            chk({30'h0, timer_pin_oe}, 32'h1 << i);
            chk({31'h0, irq}, 32'h0);
            rdx(OFS_INT_STAT, 32'h1 << i, RESP_OKAY);
            wro(OFS_INT_MASK, 32'h1 << i);
            repeat (2) @(negedge sys_clk);
            chk({31'h0, irq}, 32'h1);
            wro(OFS_CTRL, 32'h0);
            wro(OFS_INT_STAT, 32'h1 << i);
            rdx(OFS_INT_STAT, 32'h0, RESP_OKAY);
            chk({31'h0, irq}, 32'h0);
        end
        // kicks spaced well inside the period keep the watchdog quiet
        wro(OFS_T1_PERIOD, 32'h28);
        wro(OFS_CTRL, 32'h12);
        repeat (3) begin
            repeat (10) @(posedge sys_clk);
            wro(OFS_WD_KICK, 32'h1);
        end
        chk(n_resets, 0);
        do @(negedge sys_clk); while (!watchdog_reset_out);
        chk({31'h0, core_reset_req}, 32'h1);
        chk({31'h0, watchdog_reset_out_oe}, 32'h1);
        rdx(OFS_CTRL, 32'h0, RESP_OKAY);
        do @(negedge sys_clk); while (watchdog_reset_out);
        @(negedge sys_clk);
        chk(n_resets, 1);
        chk(last_len >= HOLD, 1);
        wro(OFS_T0_PERIOD, 32'h3);
        wro(OFS_INT_MASK, 32'h3);
        wro(OFS_CTRL, 32'h61);
        repeat (10) @(posedge sys_clk);
        chip_reset_low_in <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk({31'h0, core_reset_req}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        chk({29'h0, watchdog_reset_out_oe, timer_pin_oe}, 32'h0);
        repeat (256) @(posedge sys_clk);
        chip_reset_low_in <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rdx(OFS_CTRL, 32'h0, RESP_OKAY);
        rdx(OFS_INT_MASK, 32'h0, RESP_OKAY);
        print_verdict();
    end
endmodule

bind twd_timer_wdog twd_timer_wdog_checker
    #(.WRST_HOLD_CYCLES(WRST_HOLD_CYCLES)) twd_timer_wdog_checker_i (.*);
